// >>> verification/cbx_op_unit_tb_top.sv
// Self-checking bench for the translation operation unit
`timescale 1ns/1ns
module cbx_op_unit_tb_top;
  import cbx_pkg::*;
  logic             clk = 1'b0, rst_n = 1'b0, sup = 1'b1, absent = 1'b0, op_wr = 1'b0;
  logic [1:0]       op_sel = 2'h0;
  logic [IA_W-1:0]  op_addr = '0;
  logic [BANK_W-1:0] bank = 8'h5a;
  logic             g_wr = 1'b0, linked = 1'b0, stall_en = 1'b0, huf = 1'b1, ctx_fault_report_en = 1'b1;
  logic             res_wr = 1'b0, res_term = 1'b0, cclr = 1'b0, gclr = 1'b0, wdone = 1'b0;
  logic [2:0]       wres = 3'h0;
  logic [PA_W-1:0]  wipa = '0, result;
  logic [FS_W-1:0]  wcode = '0, cfs, gfs;
  logic             wreq, wnest, g_ack, busy;
  logic [1:0]       wop;
  logic [IA_W-1:0]  waddr, cfa;
  logic [SYN_W-1:0] csyn, gsyn0, gsyn2;
  int               n_errors = 0, total_checks = 0;
  localparam logic [PA_W-1:0] IPA = 64'hfedc_ba98_7654_3abc;
  localparam logic [PA_W-1:0] IPA_RES = 64'hfedc_ba98_7654_3000;
  localparam logic [IA_W-1:0] NA = 48'h9876_5432_1000;

  cbx_op_unit i_cbx_op_unit (.CLK(clk), .RST_N(rst_n), .STAGE1_SUPPORTED_FLAG(sup),
    .XLATE_OPS_ABSENT_FLAG(absent), .OP_WR(op_wr), .OP_SEL(op_sel), .OP_ADDR(op_addr),
    .S1_BANK_INDEX(bank), .GLOB_TWO_STAGE_WR(g_wr), .S2_LINKED(linked),
    .S2_STALL_EN(stall_en), .HIT_UNDER_FAULT_EN(huf), .CTX_FAULT_REPORT_EN(ctx_fault_report_en),
    .CTX_RESUME_WR(res_wr), .CTX_RESUME_TERMINATE(res_term), .CTX_FAULT_CLR(cclr),
    .GLOB_FAULT_CLR(gclr), .WALK_DONE(wdone), .WALK_RESULT(wres), .WALK_IPA(wipa),
    .WALK_FAULT_CODE(wcode), .WALK_REQ(wreq), .WALK_OP(wop), .WALK_ADDR(waddr),
    .WALK_NESTED(wnest), .GLOB_TWO_STAGE_ACK(g_ack), .XLATE_RESULT_REG(result),
    .XLATE_STATUS_REG(busy), .CTX_FAULT_STATUS(cfs), .CTX_FAULT_ADDR(cfa),
    .CTX_FAULT_SYNDROME0(csyn), .GLOB_FAULT_STATUS(gfs), .GLOB_SYNDROME0(gsyn0),
    .GLOB_SYNDROME2(gsyn2));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cfg(input logic l, input logic s, input logic h);
    @(posedge clk);
    linked <= l;
    stall_en <= s;
    huf <= h;
  endtask

  // Bounded wait for a one-cycle pulse, sampled mid-cycle
  task automatic wait_hi(ref logic sig, input string nm);
    int i;
    i = 0;
    while (sig !== 1'b1 && i < 8) begin
      @(negedge clk);
      i++;
    end
    chk(nm, sig, 1'b1);
  endtask

  task automatic start_op(input logic [1:0] sel, input logic [IA_W-1:0] a);
    @(posedge clk);
    op_wr <= 1'b1;
    op_sel <= sel;
    op_addr <= a;
    @(posedge clk);
    op_wr <= 1'b0;
    wait_hi(wreq, "walk_req");
    chk("walk_op", wop, sel);
    chk("walk_addr", waddr, a);
    chk("walk_nested", wnest, linked);
    chk("busy_start", busy, 1'b1);
  endtask

  // Result, busy and fault registers all settle on the same edge
  task automatic walk_ans(input logic [2:0] r, input logic [FS_W-1:0] code,
                          input logic eb, input logic [PA_W-1:0] er);
    @(posedge clk);
    wdone <= 1'b1;
    wres <= r;
    wipa <= IPA;
    wcode <= code;
    @(posedge clk);
    wdone <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("busy", busy, eb);
    if (!eb) chk("result", result, er);
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic clr_all;
    @(posedge clk);
    cclr <= 1'b1;
    gclr <= 1'b1;
    @(posedge clk);
    cclr <= 1'b0;
    gclr <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("cfs_clr", cfs, 32'h0);
    chk("gfs_clr", gfs, 32'h0);
  endtask

  task automatic t_disabled;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      sup <= k[0];
      absent <= k[0];
      op_wr <= 1'b1;
      @(posedge clk);
      op_wr <= 1'b0;
      repeat (4) begin
        @(negedge clk);
        chk("off_busy", busy, 1'b0);
        chk("off_res", result, 64'h0);
      end
    end
    @(posedge clk);
    sup <= 1'b1;
    absent <= 1'b0;
    $display("test disabled done");
  endtask

  task automatic t_plain;
    for (int k = 0; k < 4; k++) begin
      start_op(2'(k), 48'h8abc_def0_0000 | {34'h0, 2'(k), 12'h0});
      walk_ans(3'h0, 32'h0, 1'b0, IPA_RES);
    end
    start_op(OP_PR, NA);
    walk_ans(3'h1, 32'h0000_0a04, 1'b0, 64'h0000_0000_0000_0a05);
    @(posedge clk);
    g_wr <= 1'b1;
    @(posedge clk);
    g_wr <= 1'b0;
    wait_hi(g_ack, "glob_ack");
    $display("test plain done");
  endtask

  task automatic resume(input logic term);
    @(posedge clk);
    res_wr <= 1'b1;
    res_term <= term;
    @(posedge clk);
    res_wr <= 1'b0;
    if (!term) wait_hi(wreq, "retry_req");
  endtask

  task automatic t_nested;
    logic [FS_W-1:0] pfs;
    logic [SYN_W-1:0] psyn;
    clr_all;
    cfg(1'b1, 1'b1, 1'b1);
    start_op(OP_PW, NA);
    walk_ans(3'h2, 32'h0000_0008, 1'b1, 64'h0);
    chk("s2_multi", cfs[FS_MULTI_BIT], 1'b0);
    chk("s2_rec", |cfs, 1'b1);
    chk("s2_addr", cfa, NA);
    chk("s2_syn", {csyn[SYN_OPF_BIT], csyn[SYN_S1W_BIT], csyn[SYN_IDX_LSB+:BANK_W]},
        {2'b11, bank});
    resume(1'b0);
    walk_ans(3'h0, 32'h0, 1'b0, IPA_RES);
    pfs = cfs;
    psyn = csyn;
    start_op(OP_UR, 48'h0000_1111_2000);
    walk_ans(3'h2, 32'h0000_0004, 1'b0, RES_OP_TERMINATED_CODE_CODE);
    chk("s2_multi_set", cfs, pfs | 32'h8000_0000);
    chk("s2_syn_kept", csyn, psyn);
    chk("s2_addr_kept", cfa, NA);
    cfg(1'b1, 1'b1, 1'b0);
    start_op(OP_UW, NA);
    walk_ans(3'h0, 32'h0, 1'b0, RES_OP_TERMINATED_CODE_CODE);
    clr_all;
    cfg(1'b1, 1'b1, 1'b1);
    start_op(OP_PR, NA);
    walk_ans(3'h2, 32'h0000_0008, 1'b1, 64'h0);
    resume(1'b1);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("term_busy", busy, 1'b0);
    chk("term_res", result, RES_OP_TERMINATED_CODE_CODE);
    clr_all;
    cfg(1'b1, 1'b0, 1'b1);
    @(posedge clk);
    ctx_fault_report_en <= 1'b0;
    start_op(OP_PR, NA);
    walk_ans(3'h2, 32'h0000_0008, 1'b0, RES_OP_TERMINATED_CODE_CODE);
    chk("term_rec", |cfs, 1'b1);
    $display("test nested done");
  endtask

  task automatic t_global;
    logic [FS_W-1:0] pfs;
    logic [SYN_W-1:0] psyn;
    clr_all;
    cfg(1'b1, 1'b1, 1'b1);
    start_op(OP_UR, NA);
    walk_ans(3'h3, 32'h0000_0002, 1'b0, RES_OP_TERMINATED_CODE_CODE);
    chk("g_rec", |gfs, 1'b1);
    chk("g_syn0", {gsyn0[GSY_XOP_BIT], gsyn0[GSY_NSAT_BIT], gsyn0[GSY_NSST_BIT],
        gsyn0[GSY_NESTED_BIT]}, 4'hf);
    chk("g_syn2", gsyn2, GSY2_IMPL);
    pfs = gfs;
    psyn = gsyn0;
    start_op(OP_PW, 48'h0000_2222_3000);
    walk_ans(3'h3, 32'h0000_0004, 1'b0, RES_OP_TERMINATED_CODE_CODE);
    chk("g_multi", gfs, pfs | 32'h8000_0000);
    chk("g_syn_kept", gsyn0, psyn);
    @(posedge clk);
    absent <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("off_res_late", result, 64'h0);
    @(posedge clk);
    absent <= 1'b0;
    $display("test global done");
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    stop_test;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_disabled;
    t_plain;
    t_nested;
    t_global;
    stop_test;
  end
endmodule

// >>> verilog/cbx_op_unit.sv
// Stage 1 context-bank address translation operation unit with nested fault handling
`timescale 1ns/1ns
module cbx_op_unit
  import cbx_pkg::*;
(
  input  wire logic                         CLK,
  input  wire logic                         RST_N,
  input  wire logic                         STAGE1_SUPPORTED_FLAG,
  input  wire logic                         XLATE_OPS_ABSENT_FLAG,
  input  wire logic                         OP_WR,
  input  wire logic [1:0]                   OP_SEL,
  input  wire logic [cbx_pkg::IA_W-1:0]     OP_ADDR,
  input  wire logic [cbx_pkg::BANK_W-1:0]   S1_BANK_INDEX,
  input  wire logic                         GLOB_TWO_STAGE_WR,
  input  wire logic                         S2_LINKED,
  input  wire logic                         S2_STALL_EN,
  input  wire logic                         HIT_UNDER_FAULT_EN,
  input  wire logic                         CTX_FAULT_REPORT_EN,
  input  wire logic                         CTX_RESUME_WR,
  input  wire logic                         CTX_RESUME_TERMINATE,
  input  wire logic                         CTX_FAULT_CLR,
  input  wire logic                         GLOB_FAULT_CLR,
  input  wire logic                         WALK_DONE,
  input  wire logic [2:0]                   WALK_RESULT,
  input  wire logic [cbx_pkg::PA_W-1:0]     WALK_IPA,
  input  wire logic [cbx_pkg::FS_W-1:0]     WALK_FAULT_CODE,
  output logic                              WALK_REQ,
  output logic [1:0]                        WALK_OP,
  output logic [cbx_pkg::IA_W-1:0]          WALK_ADDR,
  output logic                              WALK_NESTED,
  output logic                              GLOB_TWO_STAGE_ACK,
  output logic [cbx_pkg::PA_W-1:0]          XLATE_RESULT_REG,
  output logic                              XLATE_STATUS_REG,
  output logic [cbx_pkg::FS_W-1:0]          CTX_FAULT_STATUS,
  output logic [cbx_pkg::IA_W-1:0]          CTX_FAULT_ADDR,
  output logic [cbx_pkg::SYN_W-1:0]         CTX_FAULT_SYNDROME0,
  output logic [cbx_pkg::FS_W-1:0]          GLOB_FAULT_STATUS,
  output logic [cbx_pkg::SYN_W-1:0]         GLOB_SYNDROME0,
  output logic [cbx_pkg::SYN_W-1:0]         GLOB_SYNDROME2
);
  import cbx_pkg::*;

  cbx_state_e             state_q;
  cbx_state_e             state_d;
  logic                   ops_en;
  logic                   start;
  logic [IA_W-1:0]        addr_q;
  logic [1:0]             op_q;
  logic [PA_W-1:0]        res_q;
  logic                   busy_q;
  logic [FS_W-1:0]        cfs_q;
  logic [IA_W-1:0]        cfa_q;
  logic [SYN_W-1:0]       csy_q;
  logic [FS_W-1:0]        gfs_q;
  logic [SYN_W-1:0]       gsy_q;
  logic [SYN_W-1:0]       gsy2_q;
  logic                   req_q;
  logic                   gack_q;
  logic                   w_s2;
  logic                   w_glb;
  logic                   w_ok;
  logic                   s2_busy;
  logic                   hit_term;
  logic                   s2_term;
  logic                   s2_stall;
  logic                   glb_term;

  assign ops_en = STAGE1_SUPPORTED_FLAG && !XLATE_OPS_ABSENT_FLAG;
  // A write while busy is taken as ignored; software must not issue one
  assign start = ops_en && OP_WR && (state_q == CBX_IDLE);

  assign w_ok = WALK_DONE && (WALK_RESULT == CBX_W_OK);
  assign w_s2 = WALK_DONE && S2_LINKED && (WALK_RESULT == CBX_W_S2FLT);
  assign w_glb = WALK_DONE && S2_LINKED && (WALK_RESULT == CBX_W_GLBFLT);
  assign s2_busy = (cfs_q != FS_RESET);
  // Stage 2 already faulting and refusing hits kills even a good walk
  assign hit_term = WALK_DONE && S2_LINKED && s2_busy && !HIT_UNDER_FAULT_EN
                    && (WALK_RESULT != CBX_W_GLBFLT);
  assign s2_stall = w_s2 && !s2_busy && S2_STALL_EN && !hit_term;
  assign s2_term = w_s2 && !s2_stall;
  assign glb_term = w_glb;
  // Report enable is left unread on purpose: termination loads its code either way
  // Walker answers arriving outside the walk state are dropped by the state machine

  always_comb begin
    state_d = state_q;
    case (state_q)
      CBX_IDLE:  if (start) state_d = CBX_WALK;
      CBX_WALK:  if (WALK_DONE) state_d = s2_stall ? CBX_STALL : CBX_DONE;
      CBX_STALL: if (CTX_RESUME_WR && CTX_RESUME_TERMINATE) begin
                   state_d = CBX_DONE;
                 end else if (CTX_RESUME_WR) begin
                   state_d = CBX_WALK;
                 end
      CBX_DONE:  state_d = CBX_IDLE;
      default:   state_d = CBX_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) state_q <= CBX_IDLE;
    else state_q <= state_d;
  end

  // Full-width address captured as written; no extension applied
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_q <= '0;
      op_q <= OP_UR;
    end else if (start) begin
      addr_q <= OP_ADDR;
      op_q <= OP_SEL;
    end
  end

  // Walk request re-issued on a retry resume from a stall
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) req_q <= 1'b0;
    else req_q <= start || (state_q == CBX_STALL && CTX_RESUME_WR && !CTX_RESUME_TERMINATE);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) gack_q <= 1'b0;
    else gack_q <= ops_en && GLOB_TWO_STAGE_WR;
  end

  // Busy rises with the start and falls in the same edge that loads the result
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) busy_q <= 1'b0;
    else if (start) busy_q <= 1'b1;
    else if (state_q == CBX_WALK && WALK_DONE && !s2_stall) busy_q <= 1'b0;
    else if (state_q == CBX_STALL && CTX_RESUME_WR && CTX_RESUME_TERMINATE) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      res_q <= RES_RESET;
    end else if (state_q == CBX_WALK && WALK_DONE && !s2_stall) begin
      if (hit_term || s2_term || glb_term) res_q <= RES_OP_TERMINATED_CODE_CODE;
      else if (w_ok) res_q <= {WALK_IPA[PA_W-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
      else res_q <= {{(PA_W-FS_W){1'b0}}, WALK_FAULT_CODE} | RES_FAULT_BIT;
    end else if (state_q == CBX_STALL && CTX_RESUME_WR && CTX_RESUME_TERMINATE) begin
      res_q <= RES_OP_TERMINATED_CODE_CODE;
    end
  end

  // Stage 2 bank fault record; new fault wins over a same-cycle clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfs_q <= FS_RESET;
      cfa_q <= '0;
      csy_q <= '0;
    end else if (state_q == CBX_WALK && w_s2 && !s2_busy) begin
      cfs_q <= WALK_FAULT_CODE;
      cfa_q <= addr_q;
      csy_q <= '0;
      csy_q[SYN_OPF_BIT] <= 1'b1;
      csy_q[SYN_S1W_BIT] <= 1'b1;
      csy_q[SYN_IDX_LSB +: BANK_W] <= S1_BANK_INDEX;
    end else if (state_q == CBX_WALK && w_s2) begin
      cfs_q[FS_MULTI_BIT] <= 1'b1;
    end else if (CTX_FAULT_CLR) begin
      cfs_q <= FS_RESET;
    end
  end

  // Global fault record; unknown fields are left as zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gfs_q <= FS_RESET;
      gsy_q <= '0;
      gsy2_q <= '0;
    end else if (state_q == CBX_WALK && w_glb && gfs_q == FS_RESET) begin
      gfs_q <= WALK_FAULT_CODE;
      gsy_q <= '0;
      gsy_q[GSY_NESTED_BIT] <= 1'b1;
      gsy_q[GSY_NSST_BIT] <= 1'b1;
      gsy_q[GSY_NSAT_BIT] <= 1'b1;
      gsy_q[GSY_XOP_BIT] <= 1'b1;
      gsy2_q <= GSY2_IMPL;
    end else if (state_q == CBX_WALK && w_glb) begin
      gfs_q[FS_MULTI_BIT] <= 1'b1;
    end else if (GLOB_FAULT_CLR) begin
      gfs_q <= FS_RESET;
    end
  end

  // Result and status views read zero when operations are absent; fault record views are not gated
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      XLATE_RESULT_REG <= RES_RESET;
      XLATE_STATUS_REG <= 1'b0;
    end else begin
      XLATE_RESULT_REG <= ops_en ? res_q : RES_RESET;
      XLATE_STATUS_REG <= ops_en ? busy_q : 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WALK_REQ <= 1'b0;
      WALK_OP <= OP_UR;
      WALK_ADDR <= '0;
      WALK_NESTED <= 1'b0;
      GLOB_TWO_STAGE_ACK <= 1'b0;
      CTX_FAULT_STATUS <= FS_RESET;
      CTX_FAULT_ADDR <= '0;
      CTX_FAULT_SYNDROME0 <= '0;
      GLOB_FAULT_STATUS <= FS_RESET;
      GLOB_SYNDROME0 <= '0;
      GLOB_SYNDROME2 <= '0;
    end else begin
      WALK_REQ <= req_q;
      WALK_OP <= op_q;
      WALK_ADDR <= addr_q;
      WALK_NESTED <= S2_LINKED;
      GLOB_TWO_STAGE_ACK <= gack_q;
      CTX_FAULT_STATUS <= cfs_q;
      CTX_FAULT_ADDR <= cfa_q;
      CTX_FAULT_SYNDROME0 <= csy_q;
      GLOB_FAULT_STATUS <= gfs_q;
      GLOB_SYNDROME0 <= gsy_q;
      GLOB_SYNDROME2 <= gsy2_q;
    end
  end

  sequence op_started_s;
    start;
  endsequence

  sequence busy_seen_s;
    ##2 XLATE_STATUS_REG;
  endsequence

  start_sets_busy_a: assert property (@(posedge CLK) disable iff (!RST_N)
    op_started_s |-> busy_seen_s) else $error("busy not shown after start");
  absent_reads_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $past(!ops_en) |-> (XLATE_RESULT_REG == RES_RESET && !XLATE_STATUS_REG))
    else $error("absent ops visible");
  no_start_absent_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!ops_en && state_q != CBX_STALL) |=> !req_q) else $error("walk while ops absent");
  stall_keeps_busy_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_STALL) |-> busy_q) else $error("busy dropped in stall");
  term_code_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_WALK && (s2_term || glb_term)) |=> (res_q == RES_OP_TERMINATED_CODE_CODE && !busy_q))
    else $error("terminate code missing");
  hit_term_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_WALK && hit_term && w_ok) |=> res_q == RES_OP_TERMINATED_CODE_CODE)
    else $error("hit under fault not terminated");
  ctx_multi_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_WALK && w_s2 && s2_busy) |=> (cfs_q[FS_MULTI_BIT] && $stable(cfa_q)))
    else $error("stage 2 multi wrong");
  ctx_record_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_WALK && w_s2 && !s2_busy) |=> (cfa_q == addr_q && csy_q[SYN_OPF_BIT]))
    else $error("stage 2 record wrong");
  glob_multi_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_WALK && w_glb && gfs_q != FS_RESET) |=> $stable(gsy_q))
    else $error("global syndrome changed");
  ok_result_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_WALK && w_ok && !hit_term) |=> res_q[PA_W-1:PAGE_LSB]
      == $past(WALK_IPA[PA_W-1:PAGE_LSB])) else $error("IPA not stored");

  // Walk completion that ends the operation without a stall
  sequence walk_end_s;
    state_q == CBX_WALK && WALK_DONE && !s2_stall;
  endsequence

  // Retry write arriving while parked in the stall state
  sequence stall_retry_s;
    state_q == CBX_STALL && CTX_RESUME_WR && !CTX_RESUME_TERMINATE;
  endsequence

  // Handshake and capture checks
  start_req_a: assert property (@(posedge CLK) disable iff (!RST_N)
    op_started_s |=> req_q) else $error("walk request missing");
  req_out_a: assert property (@(posedge CLK) disable iff (!RST_N)
    req_q |=> WALK_REQ) else $error("walk request not driven");
  addr_capture_a: assert property (@(posedge CLK) disable iff (!RST_N)
    op_started_s |=> addr_q == $past(OP_ADDR)) else $error("address altered");
  nested_out_a: assert property (@(posedge CLK) disable iff (!RST_N)
    S2_LINKED |=> WALK_NESTED) else $error("nested walk not flagged");
  glob_ack_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (ops_en && GLOB_TWO_STAGE_WR) |=> gack_q) else $error("global op refused");

  // Completion and stall checks
  walk_end_a: assert property (@(posedge CLK) disable iff (!RST_N)
    walk_end_s |=> (!busy_q && state_q == CBX_DONE)) else $error("busy kept after walk");
  idle_not_busy_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_IDLE) |-> !busy_q) else $error("busy while idle");
  // Views lag the internal state by one edge, so result and busy stay paired
  views_pair_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ops_en |=> (XLATE_STATUS_REG == $past(busy_q) && XLATE_RESULT_REG == $past(res_q)))
    else $error("result and busy views split");
  s1_fault_code_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_WALK && WALK_DONE && WALK_RESULT == CBX_W_S1FLT && !hit_term)
    |=> res_q[0]) else $error("fault code not marked");
  stall_res_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_STALL && !CTX_RESUME_WR) |=> $stable(res_q))
    else $error("result moved in stall");
  retry_a: assert property (@(posedge CLK) disable iff (!RST_N)
    stall_retry_s |=> (req_q && busy_q && state_q == CBX_WALK))
    else $error("retry not issued");
  resume_term_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_STALL && CTX_RESUME_WR && CTX_RESUME_TERMINATE)
    |=> (res_q == RES_OP_TERMINATED_CODE_CODE && !busy_q)) else $error("resume terminate wrong");

  // Global fault stall and record checks
  glob_no_stall_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_WALK && w_glb) |=> (state_q == CBX_DONE && !busy_q))
    else $error("global fault stalled");
  glob_record_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == CBX_WALK && w_glb && gfs_q == FS_RESET) |=> (gsy_q[GSY_NESTED_BIT]
      && gsy_q[GSY_NSST_BIT] && gsy_q[GSY_NSAT_BIT] && gsy_q[GSY_XOP_BIT]
      && gsy2_q == GSY2_IMPL)) else $error("global syndrome not set");
endmodule

// >>> verilog/cbx_pkg.sv
// Constants and types for the context-bank translation operation unit
package cbx_pkg;
  localparam int IA_W = 48;
  localparam int PA_W = 64;
  localparam int FS_W = 32;
  localparam int BANK_W = 8;
  localparam int SYN_W = 32;
  localparam logic [1:0] OP_UR = 2'h0;
  localparam logic [1:0] OP_UW = 2'h1;
  localparam logic [1:0] OP_PR = 2'h2;
  localparam logic [1:0] OP_PW = 2'h3;
  localparam int PAGE_LSB = 12;
  // Result layout: bit 0 set marks a fault code
  localparam logic [PA_W-1:0] RES_FAULT_BIT = 64'h0000_0000_0000_0001;
  localparam logic [PA_W-1:0] RES_OP_TERMINATED_CODE_CODE = 64'h0000_0000_0000_0081;
  localparam logic [PA_W-1:0] RES_RESET = 64'h0;
  localparam int FS_MULTI_BIT = 31;
  localparam logic [FS_W-1:0] FS_RESET = 32'h0;
  // Context syndrome field positions
  localparam int SYN_OPF_BIT = 11;
  localparam int SYN_S1W_BIT = 10;
  localparam int SYN_IDX_LSB = 16;
  // Global syndrome0 field positions
  localparam int GSY_NESTED_BIT = 0;
  localparam int GSY_WNR_BIT = 1;
  localparam int GSY_PNU_BIT = 2;
  localparam int GSY_IND_BIT = 3;
  localparam int GSY_NSST_BIT = 4;
  localparam int GSY_NSAT_BIT = 5;
  localparam int GSY_XOP_BIT = 6;
  localparam logic [SYN_W-1:0] GSY2_IMPL = 32'h0;
  // Walker outcome classes
  typedef enum logic [2:0] {
    CBX_W_OK     = 3'h0,
    CBX_W_S1FLT  = 3'h1,
    CBX_W_S2FLT  = 3'h2,
    CBX_W_GLBFLT = 3'h3
  } cbx_wres_e;
  typedef enum logic [3:0] {
    CBX_IDLE  = 4'b0001,
    CBX_WALK  = 4'b0010,
    CBX_STALL = 4'b0100,
    CBX_DONE  = 4'b1000
  } cbx_state_e;
endpackage
